// ### core/fis_pkg.sv
// shared constants and carrier types for the integer load/store stack controller
// assumes one system clock; the host hands over decoded instruction bytes and operand checks
package fis_pkg;
  // register map, byte addresses on the plain register port
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TAG = 8'h08;
  localparam logic [7:0] REG_ENV = 8'h0C;
  localparam logic [7:0] REG_IP = 8'h10;
  localparam logic [7:0] REG_DP = 8'h14;
  localparam logic [7:0] REG_OPC = 8'h18;
  // environment register bits
  localparam int ENV_EMU = 0;
  localparam int ENV_TSW = 1;
  localparam int ENV_ALN = 2;
  // status word fields and the control word rounding field
  localparam int SW_IE = 0;
  localparam int SW_DE = 1;
  localparam int SW_PE = 5;
  localparam int SW_SF = 6;
  localparam int SW_ES = 7;
  localparam int SW_C0 = 8;
  localparam int SW_CF1 = 9;
  localparam int SW_C2 = 10;
  localparam int SW_TOP = 11;
  localparam int SW_C3 = 14;
  localparam int CW_RND = 10;
  // reset and initialise values
  localparam logic [15:0] CTRL_INIT = 16'h037F;
  localparam logic [15:0] STATUS_INIT = 16'h0000;
  localparam logic [15:0] TAG_INIT = 16'hFFFF;
  // tag codes
  localparam logic [1:0] TAG_VALID = 2'h0;
  localparam logic [1:0] TAG_ZERO = 2'h1;
  localparam logic [1:0] TAG_EMPTY = 2'h3;
  // opcodes
  localparam logic [7:0] OPC_DF = 8'hDF;
  localparam logic [7:0] OPC_DB = 8'hDB;
  localparam logic [7:0] OPC_D9 = 8'hD9;
  localparam logic [7:0] OPC_DE = 8'hDE;
  localparam logic [7:0] OPC_DA = 8'hDA;
  localparam logic [7:0] MODRM_INCSTP = 8'hF7;
  localparam logic [7:0] MODRM_INIT = 8'hE3;
  localparam logic [1:0] CPL_USER = 2'h3;
  // extended-real encoding
  localparam logic [14:0] EXP_BIAS = 15'h3FFF;
  localparam logic [14:0] EXP_MAX = 15'h7FFF;
  localparam logic [14:0] EXP_INT_MAX = 15'h403E;
  localparam logic [79:0] EXT_INDEF = 80'hFFFF_C000_0000_0000_0000;
  // rounding modes
  localparam logic [1:0] RND_NEAR = 2'h0;
  localparam logic [1:0] RND_DOWN = 2'h1;
  localparam logic [1:0] RND_UP = 2'h2;
  typedef enum logic [1:0] {SZ16 = 2'h0, SZ32 = 2'h1, SZ64 = 2'h2} fis_size_t;
  typedef enum logic [2:0] {
    FLT_NONE = 3'h0, FLT_NAV = 3'h1, FLT_MF = 3'h2, FLT_PROT = 3'h3,
    FLT_SS = 3'h4, FLT_PAGE = 3'h5, FLT_ALIGN = 3'h6, FLT_UD = 3'h7
  } fis_fault_kind_t;
  typedef struct packed {
    logic wait_pfx;
    logic [7:0] opcode;
    logic [7:0] modrm;
    logic [31:0] ip;
    logic [31:0] ea;
  } fis_ins_t;
  typedef struct packed {
    logic seg_limit;
    logic null_sel;
    logic ss_limit;
    logic page_miss;
    logic [31:0] page_code;
    logic unaligned;
    logic nonwritable;
    logic [1:0] cpl;
  } fis_chk_t;
  typedef struct packed {
    fis_fault_kind_t kind;
    logic [31:0] err;
  } fis_fault_t;
  typedef struct packed {
    logic valid;
    fis_size_t size;
    logic [63:0] data;
  } fis_store_t;
  typedef struct packed {
    logic invalid;
    logic inexact;
    logic up;
    logic [63:0] data;
    logic [63:0] indef;
  } fis_cvt_t;
endpackage

// ### core/fis_ctl.sv
// integer load/store, stack-top increment and unit initialise execution controller
// assumes the host presents one instruction per valid pulse with its operand and checks
// How it works
// - compare flags stack, invalid, denormal operand faults
// - emulate or task-switched bit blocks every decoded instruction
// - segment limit or null selector gives gp(0)
// - unaligned access at level 3 gives ac(0)
// - decode three integer load sizes
// - exact convert, decrement top, write new top
// - push overflow sets flag one, else clears
// - stack-top increment wraps seven to zero
// - increment keeps registers, tags; clears flag one
// - init sets control, status, tags to defaults
// - init zeroes pointers, opcode, condition flags
// - waiting init first services pending exception
// - decode plain and popping store sizes
// - popping store that writes empties top, increments top
// - store rounds by rounding control field
// - invalid store: no write or indefinite
// - store clears flag one on underflow, sets it on round-up
// - empty top stack fault; unwritable gives gp
// - stack segment limit and page miss faults
// - init and increment raise no fp exception
`timescale 1ns/1ps
`default_nettype none
module fis_ctl (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // instruction and operand path
  input wire logic i_ins_valid,
  input wire fis_pkg::fis_ins_t i_ins,
  input wire logic [63:0] i_mem_data,
  input wire fis_pkg::fis_chk_t i_chk,
  // results
  output logic o_done,
  output fis_pkg::fis_fault_t o_fault,
  output fis_pkg::fis_store_t o_store,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata
);
  // exact signed integer to extended real
  function automatic logic [79:0] int_to_ext(input logic [63:0] src);
    logic [63:0] mag;
    logic [5:0] msb;
    mag = src[63] ? (64'h0 - src) : src;
    msb = 6'h0;
    for (int i = 0; i < 64; i++) begin
      if (mag[i]) msb = 6'(i);
    end
    if (mag == 64'h0) return 80'h0;
    return {src[63], 15'(fis_pkg::EXP_BIAS + 15'(msb)), 64'(mag << (6'h3F - msb))};
  endfunction
  // extended real to integer with rounding and range check
  function automatic fis_pkg::fis_cvt_t ext_to_int(input logic [79:0] v, input logic [1:0] rc,
                                                   input fis_pkg::fis_size_t sz);
    logic sgn;
    logic [14:0] ex;
    logic [63:0] man, whole, frac;
    logic [127:0] sh;
    logic [15:0] amt;
    logic [64:0] mag, lim;
    fis_pkg::fis_cvt_t r;
    r = '0;
    sgn = v[79];
    ex = v[78:64];
    man = v[63:0];
    amt = 16'(fis_pkg::EXP_INT_MAX) - {1'b0, ex};
    lim = (sz == fis_pkg::SZ16) ? 65'h8000 : (sz == fis_pkg::SZ32) ? 65'h8000_0000 :
          65'h8000_0000_0000_0000;
    r.indef = lim[63:0];
    whole = 64'h0;
    frac = 64'h0;
    r.up = 1'b0;
    if (ex > fis_pkg::EXP_INT_MAX) begin
      // too big for any width, infinity or nan
      r.invalid = 1'b1;
    end else if (amt > 16'h007F) begin
      // far below one: only a sticky fraction is left
      frac = (man != 64'h0) ? 64'h1 : 64'h0;
    end else begin
      sh = {man, 64'h0} >> amt[6:0];
      whole = sh[127:64];
      frac = sh[63:0];
    end
    if (ex != 15'h0 && !man[63]) r.invalid = 1'b1; // unsupported encoding
    unique case (rc)
      fis_pkg::RND_NEAR: r.up = frac[63] & ((|frac[62:0]) | whole[0]);
      fis_pkg::RND_DOWN: r.up = sgn & (|frac);
      fis_pkg::RND_UP: r.up = !sgn & (|frac);
      default: r.up = 1'b0;
    endcase
    mag = {1'b0, whole} + {64'h0, r.up};
    if (mag > lim || (mag == lim && !sgn)) r.invalid = 1'b1;
    r.inexact = |frac;
    r.data = sgn ? (64'h0 - mag[63:0]) : mag[63:0];
    return r;
  endfunction
  // sign-extend a memory integer by its size
  function automatic logic [63:0] sext(input logic [63:0] d, input fis_pkg::fis_size_t sz);
    if (sz == fis_pkg::SZ16) return {{48{d[15]}}, d[15:0]};
    if (sz == fis_pkg::SZ32) return {{32{d[31]}}, d[31:0]};
    return d;
  endfunction

  // architectural state
  logic [15:0] ctrl; // control word
  logic [15:0] status; // status word with top field
  logic [15:0] tag; // two bits per physical register
  logic [2:0] env; // emulate, task-switched, alignment enable
  logic [31:0] ip, dp; // last instruction and data pointers
  logic [10:0] last_opc; // saved last opcode
  logic [79:0] fpr [8]; // data registers, physical order

  // decode
  wire logic [7:0] opc = i_ins.opcode;
  wire logic [2:0] rf = i_ins.modrm[5:3];
  wire logic is_mem = i_ins.modrm[7:6] != 2'h3;
  wire logic op_load = is_mem && ((opc == fis_pkg::OPC_DF && (rf == 3'h0 || rf == 3'h5)) ||
                                  (opc == fis_pkg::OPC_DB && rf == 3'h0));
  wire logic op_store = is_mem && (((opc == fis_pkg::OPC_DF || opc == fis_pkg::OPC_DB) &&
                                    (rf == 3'h2 || rf == 3'h3)) ||
                                   (opc == fis_pkg::OPC_DF && rf == 3'h7));
  wire logic st_pop = rf != 3'h2;
  wire logic op_cmp = is_mem && (opc == fis_pkg::OPC_DE || opc == fis_pkg::OPC_DA) &&
                      (rf == 3'h2 || rf == 3'h3);
  wire logic op_incstp = opc == fis_pkg::OPC_D9 && i_ins.modrm == fis_pkg::MODRM_INCSTP;
  wire logic op_init = opc == fis_pkg::OPC_DB && i_ins.modrm == fis_pkg::MODRM_INIT;
  wire logic mem_op = op_load || op_store || op_cmp;
  wire fis_pkg::fis_size_t op_size = (rf == 3'h5 || rf == 3'h7) ? fis_pkg::SZ64 :
                                     (opc == fis_pkg::OPC_DB || opc == fis_pkg::OPC_DA) ?
                                     fis_pkg::SZ32 : fis_pkg::SZ16;

  // fault conditions in priority order
  wire logic pend_unmasked = |(status[5:0] & ~ctrl[5:0]);
  wire logic f_nav = env[fis_pkg::ENV_EMU] || env[fis_pkg::ENV_TSW];
  wire logic f_mf = op_init && i_ins.wait_pfx && pend_unmasked;
  wire logic f_prot = mem_op && (i_chk.seg_limit || i_chk.null_sel ||
                                 (op_store && i_chk.nonwritable));
  wire logic f_ss = mem_op && i_chk.ss_limit;
  wire logic f_page = mem_op && i_chk.page_miss;
  wire logic f_align = mem_op && env[fis_pkg::ENV_ALN] && i_chk.cpl == fis_pkg::CPL_USER &&
                       i_chk.unaligned;
  wire logic known = mem_op || op_incstp || op_init;
  wire fis_pkg::fis_fault_kind_t kind = !known ? fis_pkg::FLT_UD : f_nav ? fis_pkg::FLT_NAV :
                                        f_mf ? fis_pkg::FLT_MF : f_prot ? fis_pkg::FLT_PROT :
                                        f_ss ? fis_pkg::FLT_SS : f_page ? fis_pkg::FLT_PAGE :
                                        f_align ? fis_pkg::FLT_ALIGN : fis_pkg::FLT_NONE;
  wire logic go = i_ins_valid && kind == fis_pkg::FLT_NONE;

  // operands
  wire logic [2:0] top = status[13:11];
  wire logic [2:0] push_idx = top - 3'h1;
  wire logic [1:0] tag_top = tag[{top, 1'b0} +: 2];
  wire logic [1:0] tag_push = tag[{push_idx, 1'b0} +: 2];
  wire logic ld_ovf = tag_push != fis_pkg::TAG_EMPTY;
  wire logic top_empty = tag_top == fis_pkg::TAG_EMPTY;
  wire logic [79:0] st0 = fpr[top];
  wire logic [79:0] ld_ext = int_to_ext(sext(i_mem_data, op_size));
  wire fis_pkg::fis_cvt_t cvt = ext_to_int(st0, ctrl[fis_pkg::CW_RND +: 2], op_size);
  wire logic st0_nan = st0[78:64] == fis_pkg::EXP_MAX && st0[63:0] != 64'h8000_0000_0000_0000;
  wire logic st0_unsup = st0[78:64] != 15'h0 && !st0[63];
  wire logic st0_den = st0[78:64] == 15'h0 && st0[63:0] != 64'h0;
  wire logic ie_mask = ctrl[fis_pkg::SW_IE];

  // next-state logic for status, tags, data register write and store
  logic [15:0] next_ctrl, next_status, next_tag;
  logic next_wr;
  logic [2:0] next_widx;
  logic [79:0] next_wdata;
  fis_pkg::fis_store_t next_store;
  always_comb begin
    next_ctrl = ctrl;
    next_status = status;
    next_tag = tag;
    next_wr = 1'b0;
    next_widx = push_idx;
    next_wdata = ld_ext;
    next_store = '0;
    next_store.size = op_size;
    if (i_reg_wr && i_reg_addr == fis_pkg::REG_CTRL) next_ctrl = i_reg_wdata[15:0];
    if (go && op_load) begin
      if (ld_ovf) begin
        // overflow: flag and, when masked, push the indefinite value
        next_status[fis_pkg::SW_SF] = 1'b1;
        next_status[fis_pkg::SW_IE] = 1'b1;
        next_status[fis_pkg::SW_CF1] = 1'b1;
        next_wdata = fis_pkg::EXT_INDEF;
      end else begin
        next_status[fis_pkg::SW_CF1] = 1'b0;
      end
      if (!ld_ovf || ie_mask) begin
        next_status[13:11] = push_idx;
        next_wr = 1'b1;
        next_tag[{push_idx, 1'b0} +: 2] = (ld_ovf || ld_ext[78:0] != 79'h0) ?
                                          fis_pkg::TAG_VALID : fis_pkg::TAG_ZERO;
      end
    end else if (go && op_store) begin
      next_status[fis_pkg::SW_CF1] = 1'b0;
      if (top_empty || cvt.invalid) begin
        // underflow or unrepresentable: indefinite only when masked
        next_status[fis_pkg::SW_IE] = 1'b1;
        next_status[fis_pkg::SW_SF] = next_status[fis_pkg::SW_SF] | top_empty;
        next_store.valid = ie_mask;
        next_store.data = cvt.indef;
      end else begin
        next_store.valid = 1'b1;
        next_store.data = cvt.data;
        next_status[fis_pkg::SW_PE] = status[fis_pkg::SW_PE] | cvt.inexact;
        next_status[fis_pkg::SW_CF1] = cvt.inexact & cvt.up;
      end
      if (st_pop && next_store.valid) begin
        next_tag[{top, 1'b0} +: 2] = fis_pkg::TAG_EMPTY;
        next_status[13:11] = top + 3'h1;
      end
    end else if (go && op_cmp) begin
      next_status[fis_pkg::SW_CF1] = 1'b0;
      next_status[fis_pkg::SW_SF] = status[fis_pkg::SW_SF] | top_empty;
      next_status[fis_pkg::SW_IE] = status[fis_pkg::SW_IE] | top_empty |
                                    (!top_empty & (st0_nan | st0_unsup));
      next_status[fis_pkg::SW_DE] = status[fis_pkg::SW_DE] | (!top_empty & st0_den);
      if (rf == 3'h3) begin
        next_tag[{top, 1'b0} +: 2] = fis_pkg::TAG_EMPTY;
        next_status[13:11] = top + 3'h1;
      end
    end else if (go && op_incstp) begin
      next_status[13:11] = top + 3'h1;
      next_status[fis_pkg::SW_CF1] = 1'b0;
    end else if (go && op_init) begin
      next_ctrl = fis_pkg::CTRL_INIT;
      next_status = fis_pkg::STATUS_INIT;
      next_tag = fis_pkg::TAG_INIT;
    end
    if (|(next_status[5:0] & ~next_ctrl[5:0])) next_status[fis_pkg::SW_ES] = 1'b1;
  end

  // state registers; init keeps data registers untouched
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl <= fis_pkg::CTRL_INIT;
      status <= fis_pkg::STATUS_INIT;
      tag <= fis_pkg::TAG_INIT;
      env <= 3'h0;
    end else begin
      ctrl <= next_ctrl;
      status <= next_status;
      tag <= next_tag;
      if (i_reg_wr && i_reg_addr == fis_pkg::REG_ENV) env <= i_reg_wdata[2:0];
    end
  end

  // pointers follow each executed instruction, the data pointer only memory ones; init clears them
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ip <= 32'h0;
      dp <= 32'h0;
      last_opc <= 11'h000;
    end else if (go && op_init) begin
      ip <= 32'h0;
      dp <= 32'h0;
      last_opc <= 11'h000;
    end else if (go) begin
      ip <= i_ins.ip;
      dp <= mem_op ? i_ins.ea : dp;
      last_opc <= {opc[2:0], i_ins.modrm};
    end
  end

  // data registers; only a load writes them
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < 8; i++) fpr[i] <= 80'h0;
    end else if (next_wr) begin
      fpr[next_widx] <= next_wdata;
    end
  end

  // result outputs, one cycle after the instruction
  wire logic [31:0] fault_err = (kind == fis_pkg::FLT_PAGE) ? i_chk.page_code : 32'h0;
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_done <= 1'b0;
      o_fault <= '0;
      o_store <= '0;
    end else begin
      o_done <= i_ins_valid;
      o_fault.kind <= i_ins_valid ? kind : fis_pkg::FLT_NONE;
      o_fault.err <= i_ins_valid ? fault_err : 32'h0;
      o_store <= go && op_store ? next_store : '0;
    end
  end

  // register read mux; unmapped addresses read zero
  wire logic [31:0] rd_mux = (i_reg_addr == fis_pkg::REG_CTRL) ? {16'h0, ctrl} :
                             (i_reg_addr == fis_pkg::REG_STATUS) ? {16'h0, status} :
                             (i_reg_addr == fis_pkg::REG_TAG) ? {16'h0, tag} :
                             (i_reg_addr == fis_pkg::REG_ENV) ? {29'h0, env} :
                             (i_reg_addr == fis_pkg::REG_IP) ? ip :
                             (i_reg_addr == fis_pkg::REG_DP) ? dp :
                             (i_reg_addr == fis_pkg::REG_OPC) ? {21'h0, last_opc} : 32'h0;
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) o_reg_rdata <= 32'h0;
    else o_reg_rdata <= i_reg_rd ? rd_mux : 32'h0;
  end

  // checks on the executed behaviour
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  wire logic ok_ins = i_ins_valid && known && !f_nav;
  a_nav_blocks_all: assert property (
    i_ins_valid && known && f_nav |=> o_done && o_fault.kind == fis_pkg::FLT_NAV &&
    !o_store.valid) else $error("blocked unit did not report device not available");
  a_prot_code_zero: assert property (
    ok_ins && !f_mf && mem_op && i_chk.seg_limit |=> o_fault.kind == fis_pkg::FLT_PROT &&
    o_fault.err == 32'h0) else $error("segment limit did not give protection fault zero");
  a_align_user_level: assert property (
    ok_ins && mem_op && !f_prot && !f_ss && !f_page && env[fis_pkg::ENV_ALN] &&
    i_chk.unaligned && i_chk.cpl == fis_pkg::CPL_USER |=> o_fault.kind == fis_pkg::FLT_ALIGN)
    else $error("unaligned user access not faulted");
  a_load_overflow: assert property (
    go && op_load && ld_ovf |=> status[fis_pkg::SW_CF1] && status[fis_pkg::SW_SF])
    else $error("load overflow flags wrong");
  a_incstp_wrap: assert property (
    go && op_incstp |=> top == 3'($past(top) + 3'h1) && tag == $past(tag) &&
    !status[fis_pkg::SW_CF1]) else $error("stack-top increment wrong");
  a_init_defaults: assert property (
    go && op_init |=> ctrl == 16'h037F && status == 16'h0 && tag == 16'hFFFF && ip == 32'h0 &&
    last_opc == 11'h0) else $error("init defaults wrong");
  a_init_wait_pend: assert property (
    i_ins_valid && op_init && !f_nav && i_ins.wait_pfx && pend_unmasked |=>
    o_fault.kind == fis_pkg::FLT_MF && tag == $past(tag)) else $error("pending not serviced");
  a_pop_store: assert property (
    go && op_store && st_pop && !top_empty && !cvt.invalid |=> o_store.valid &&
    top == 3'($past(top) + 3'h1) && tag_push == fis_pkg::TAG_EMPTY) else $error("pop store wrong");
  a_store_invalid: assert property (
    go && op_store && !top_empty && cvt.invalid && !ie_mask |=> !o_store.valid &&
    status[fis_pkg::SW_IE]) else $error("unmasked invalid store wrote data");
  a_store_underflow: assert property (
    go && op_store && top_empty |=> status[fis_pkg::SW_SF] && !status[fis_pkg::SW_CF1])
    else $error("store underflow not flagged");
  c_load_push: cover property (go && op_load && !ld_ovf ##1 o_done);
  c_store_pop: cover property (go && op_store && st_pop ##1 o_store.valid);
  c_init_nowait: cover property (go && op_init && !i_ins.wait_pfx);
  c_incstp_wrap: cover property (go && op_incstp && top == 3'h7);
endmodule // fis_ctl
`default_nettype wire

// ### tb/fis_host_model.sv
// host-side model: instruction stream and memory operand path feeding the controller
// assumes one issue call at a time, each starting after the previous one returned
`timescale 1ns/1ps
`default_nettype none
module fis_host_model (
  // clock
  input wire logic i_clk_sys,
  // instruction and operand path
  output logic o_ins_valid,
  output fis_pkg::fis_ins_t o_ins,
  output logic [63:0] o_mem_data,
  output fis_pkg::fis_chk_t o_chk
);
  // quiet lines from time zero
  initial begin
    o_ins_valid = 1'b0;
    o_ins = '0;
    o_mem_data = '0;
    o_chk = '0;
  end
  // one valid cycle; operand lines are inverted afterwards so stale data is never reused
  task automatic issue(input logic w, input logic [7:0] opc, input logic [7:0] modrm,
                       input logic [63:0] mem, input fis_pkg::fis_chk_t c);
    @(posedge i_clk_sys);
    o_ins_valid <= 1'b1;
    o_ins <= {w, opc, modrm, 32'h0000_0100, 32'h0000_2000};
    o_mem_data <= mem;
    o_chk <= c;
    @(posedge i_clk_sys);
    o_ins_valid <= 1'b0;
    o_mem_data <= ~mem;
    o_chk <= ~c;
  endtask
endmodule // fis_host_model
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the integer load/store stack controller
// assumes the host model drives the instruction path and the bench owns the register port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk_sys = 1'b0; // 50 MHz system clock
  logic i_rstn = 1'b0; // active-low reset
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic ins_valid;
  fis_pkg::fis_ins_t ins;
  logic [63:0] mem_data;
  fis_pkg::fis_chk_t chk;
  logic done;
  fis_pkg::fis_fault_t fault;
  fis_pkg::fis_store_t store;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  logic [31:0] d;
  // clock
  always #10 i_clk_sys = ~i_clk_sys;
  fis_host_model host (.i_clk_sys(i_clk_sys), .o_ins_valid(ins_valid), .o_ins(ins),
    .o_mem_data(mem_data), .o_chk(chk));
  fis_ctl uut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ins_valid(ins_valid), .i_ins(ins),
    .i_mem_data(mem_data), .i_chk(chk), .o_done(done), .o_fault(fault), .o_store(store),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata));
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      stop_test();
    end
  end
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // register port: one-cycle strobes, read data only in the cycle after
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge i_clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge i_clk_sys);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge i_clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    rd(a, d);
    cmp(d[15:0] & m, e);
  endtask
  // one instruction; done, fault kind and code are judged in the answer cycle
  task automatic ex(input logic w, input logic [7:0] opc, input logic [7:0] m,
                    input logic [63:0] mem, input fis_pkg::fis_chk_t c,
                    input logic [2:0] kind, input logic [31:0] err);
    host.issue(w, opc, m, mem, c);
    #1 cmp(done, 1'b1);
    cmp(fault.kind, kind);
    cmp(fault.err, err);
  endtask
  task automatic ok(input logic [7:0] opc, input logic [7:0] m, input logic [63:0] mem);
    ex(1'b0, opc, m, mem, '0, fis_pkg::FLT_NONE, 32'h0);
  endtask
  // operand checks packed as {seg, null, ss, page, unaligned, nonwritable, level3}
  task automatic flt(input logic [6:0] f, input logic [7:0] m, input logic [2:0] kind,
                     input logic [31:0] err);
    fis_pkg::fis_chk_t c;
    c = '0;
    c.seg_limit = f[6];
    c.null_sel = f[5];
    c.ss_limit = f[4];
    c.page_miss = f[3];
    c.page_code = f[3] ? 32'h0000_00A5 : 32'h0;
    c.unaligned = f[2];
    c.nonwritable = f[1];
    c.cpl = f[0] ? fis_pkg::CPL_USER : 2'h0;
    ex(1'b0, fis_pkg::OPC_DF, m, 64'h1, c, kind, err);
  endtask
  task automatic t_reset();
    rdc(fis_pkg::REG_CTRL, 16'hFFFF, 16'h037F);
    rdc(fis_pkg::REG_STATUS, 16'hFFFF, 16'h0000);
    rdc(fis_pkg::REG_TAG, 16'hFFFF, 16'hFFFF);
    wr(fis_pkg::REG_ENV, 32'h5);
    rdc(fis_pkg::REG_ENV, 16'h0007, 16'h0005);
    wr(fis_pkg::REG_ENV, 32'h0);
    rdc(8'h40, 16'hFFFF, 16'h0000);
  endtask
  // three load sizes, then fill all eight registers and push once more
  task automatic t_loads();
    ok(fis_pkg::OPC_DF, 8'h00, 64'hFFFB);
    rdc(fis_pkg::REG_STATUS, 16'h3A00, 16'h3800);
    rdc(fis_pkg::REG_TAG, 16'hC000, 16'h0000);
    ok(fis_pkg::OPC_DB, 8'h00, 64'h8000_0001);
    rdc(fis_pkg::REG_STATUS, 16'h3800, 16'h3000);
    ok(fis_pkg::OPC_DF, 8'h28, 64'h7FFF_0000_0000_0003);
    rdc(fis_pkg::REG_STATUS, 16'h3800, 16'h2800);
    repeat (5) ok(fis_pkg::OPC_DF, 8'h00, 64'h1);
    rdc(fis_pkg::REG_STATUS, 16'h3800, 16'h0000);
    ok(fis_pkg::OPC_DF, 8'h00, 64'h1);
    rdc(fis_pkg::REG_STATUS, 16'h0241, 16'h0241);
  endtask
  // pending unmasked flags hold off the waiting form only
  task automatic t_init();
    wr(fis_pkg::REG_CTRL, 32'h0);
    ex(1'b1, fis_pkg::OPC_DB, 8'hE3, 64'h0, '0, fis_pkg::FLT_MF, 32'h0);
    rdc(fis_pkg::REG_STATUS, 16'h0241, 16'h0241);
    ok(fis_pkg::OPC_DB, 8'hE3, 64'h0);
    rdc(fis_pkg::REG_CTRL, 16'hFFFF, 16'h037F);
    rdc(fis_pkg::REG_STATUS, 16'hFFFF, 16'h0000);
    rdc(fis_pkg::REG_TAG, 16'hFFFF, 16'hFFFF);
    rdc(fis_pkg::REG_IP, 16'hFFFF, 16'h0000);
    rdc(fis_pkg::REG_DP, 16'hFFFF, 16'h0000);
    rdc(fis_pkg::REG_OPC, 16'hFFFF, 16'h0000);
  endtask
  // load then store back: exact round trip, plain store keeps top, pop empties it
  task automatic t_store(input logic [7:0] opc, input logic [7:0] lm, input logic [7:0] pm,
                         input logic plain, input logic [63:0] v, input logic [63:0] mk,
                         input logic [1:0] sz);
    ok(opc, lm, v);
    if (plain) begin
      ok(opc, 8'h10, 64'h0);
      cmp(store.valid, 1'b1);
      cmp(store.data & mk, v & mk);
      rdc(fis_pkg::REG_STATUS, 16'h3800, 16'h3800);
    end
    ok(opc, pm, 64'h0);
    cmp({store.valid, store.size}, {1'b1, sz});
    cmp(store.data & mk, v & mk);
    rdc(fis_pkg::REG_STATUS, 16'h3800, 16'h0000);
    rdc(fis_pkg::REG_TAG, 16'hFFFF, 16'hFFFF);
  endtask
  task automatic t_under();
    ok(fis_pkg::OPC_DF, 8'h18, 64'h0);
    cmp(store.data & 64'hFFFF, 64'h8000);
    rdc(fis_pkg::REG_STATUS, 16'h0241, 16'h0041);
    ok(fis_pkg::OPC_DB, 8'hE3, 64'h0);
    ok(fis_pkg::OPC_DE, 8'h10, 64'h3);
    rdc(fis_pkg::REG_STATUS, 16'h0241, 16'h0041);
    // unmasked invalid: a too-big popping store writes nothing and keeps top
    wr(fis_pkg::REG_CTRL, 32'h037E);
    ok(fis_pkg::OPC_DB, 8'h00, 64'h0001_0000);
    ok(fis_pkg::OPC_DF, 8'h18, 64'h0);
    cmp(store.valid, 1'b0);
    rdc(fis_pkg::REG_STATUS, 16'h3801, 16'h3801);
  endtask
  // increment wraps seven to zero and leaves the old top tagged valid
  task automatic t_incstp();
    ok(fis_pkg::OPC_DB, 8'hE3, 64'h0);
    ok(fis_pkg::OPC_DF, 8'h00, 64'h5);
    ok(fis_pkg::OPC_D9, fis_pkg::MODRM_INCSTP, 64'h0);
    cmp(store.valid, 1'b0);
    rdc(fis_pkg::REG_STATUS, 16'h3A7F, 16'h0000);
    rdc(fis_pkg::REG_TAG, 16'hC000, 16'h0000);
    ok(fis_pkg::OPC_D9, fis_pkg::MODRM_INCSTP, 64'h0);
    rdc(fis_pkg::REG_STATUS, 16'h3800, 16'h0800);
  endtask
  task automatic t_faults();
    wr(fis_pkg::REG_ENV, 32'h1);
    flt(7'h00, 8'h00, fis_pkg::FLT_NAV, 32'h0);
    wr(fis_pkg::REG_ENV, 32'h2);
    flt(7'h00, 8'h00, fis_pkg::FLT_NAV, 32'h0);
    wr(fis_pkg::REG_ENV, 32'h4);
    flt(7'h40, 8'h00, fis_pkg::FLT_PROT, 32'h0);
    flt(7'h20, 8'h00, fis_pkg::FLT_PROT, 32'h0);
    flt(7'h02, 8'h10, fis_pkg::FLT_PROT, 32'h0);
    flt(7'h10, 8'h00, fis_pkg::FLT_SS, 32'h0);
    flt(7'h08, 8'h00, fis_pkg::FLT_PAGE, 32'hA5);
    flt(7'h05, 8'h00, fis_pkg::FLT_ALIGN, 32'h0);
    flt(7'h00, 8'h08, fis_pkg::FLT_UD, 32'h0);
    rdc(fis_pkg::REG_STATUS, 16'h3800, 16'h0800);
    flt(7'h04, 8'h00, fis_pkg::FLT_NONE, 32'h0);
    rdc(fis_pkg::REG_STATUS, 16'h3800, 16'h0000);
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    t_reset();
    t_loads();
    t_init();
    t_store(fis_pkg::OPC_DF, 8'h00, 8'h18, 1'b1, 64'hFFFB, 64'hFFFF, fis_pkg::SZ16);
    t_store(fis_pkg::OPC_DB, 8'h00, 8'h18, 1'b1, 64'h8000_0001, 64'hFFFF_FFFF,
            fis_pkg::SZ32);
    t_store(fis_pkg::OPC_DF, 8'h28, 8'h38, 1'b0, 64'h8000_0000_0000_0001, '1,
            fis_pkg::SZ64);
    t_under();
    t_incstp();
    t_faults();
    stop_test();
  end
endmodule // testbench
`default_nettype wire
